// ==== tsf_bridge.sv ====
`timescale 1ns/100ps
`include "tsf_params.svh"
module tsf_bridge import tsf_pkg::*; #(
  parameter int DEPTH = `TSF_FIFO_DEPTH
) (
  input  wire logic          clk_sys,
  input  wire logic          reset,
  tsf_link_if.bridge         link,
  input  wire logic          parity_check_en,
  input  wire logic          core_ready,
  output logic               core_valid,
  output logic               core_start,
  output logic               core_end,
  output tsf_data_type       core_data,
  output logic               core_nullified,
  output tsf_pf_type         core_pf,
  output logic               core_vf_active,
  output tsf_vf_type         core_vf,
  output logic               core_parity_error,
  output logic               core_protocol_error
);
  localparam int FW = `TSF_DATA_W + 2 + 1 + `TSF_PF_W + 1 + `TSF_VF_W;
  localparam int QW = `TSF_DATA_W / `TSF_QWORD_W;
  // Beat index saturates here: only third-or-later matters for nullify
  localparam logic [1:0] NULL_BEAT = 2'(`TSF_NULL_MIN_BEATS);

  typedef struct packed {
    tsf_state_type state;
    logic [1:0]    beats;
    logic          null_seen;
    tsf_pf_type    pf;
    logic          vfa;
    tsf_vf_type    vf;
    logic          o_valid;
    logic          o_start;
    logic          o_end;
    tsf_data_type  o_data;
    logic          o_null;
    tsf_pf_type    o_pf;
    logic          o_vfa;
    tsf_vf_type    o_vf;
    logic          o_perr;
    logic          o_proto;
  } tsf_brg_st_type;
  tsf_brg_st_type s_r, s_nxt;

  logic          beat;
  logic          f_valid;
  logic          f_ready;
  logic          f_in_ready;
  logic          perr;
  logic [FW-1:0] f_in, f_out;
  tsf_data_type  clean;
  tsf_par_type   pbad;
  logic          f_start;
  logic          f_end;
  logic          f_null;
  logic          f_vfa;
  tsf_data_type  f_data;
  tsf_pf_type    f_pf;
  tsf_vf_type    f_vf;

  // ----------------------------------------
  // Ingress beat
  // ----------------------------------------
  assign beat = link.tx_beat_valid && f_in_ready;

  always_comb begin
    clean = link.tx_payload_bus;
    for (int q = 0; q < QW; q++) begin
      if (link.tx_packet_end &&
          (q >= QW - int'(link.tx_last_beat_empty_qwords)))
        clean[q*`TSF_QWORD_W +: `TSF_QWORD_W] = '0;
    end
  end

  // Checked on the raw bus so that bad upper bytes are caught as well
  genvar b;
  generate
    for (b = 0; b < `TSF_BYTES; b++) begin : g_pchk
      assign pbad[b] = ~^{link.tx_payload_bus[b*8 +: 8],
                          link.tx_byte_odd_parity[b]};
    end
  endgenerate
  assign perr = parity_check_en && (pbad != '0);

  // ----------------------------------------
  // Packet tracking and identity capture
  // ----------------------------------------
  always_comb begin
    tsf_state_type beat_state;
    beat_state = TSF_IDLE;
    s_nxt = s_r;
    s_nxt.o_perr = 1'b0;
    s_nxt.o_proto = 1'b0;
    if (beat) begin
      s_nxt.o_perr = perr;
      if (link.tx_packet_start) begin
        s_nxt.pf  = link.tx_phys_func_number;
        s_nxt.vfa = link.tx_virt_func_active;
        s_nxt.vf  = link.tx_virt_func_active
          ? link.tx_virt_func_offset : '0;
        s_nxt.beats = 2'd1;
        s_nxt.null_seen = 1'b0;
        s_nxt.o_proto = (s_r.state == TSF_IN_PKT)
          || (s_r.state == TSF_GAP);
      end else if (s_r.beats != NULL_BEAT) begin
        s_nxt.beats = s_r.beats + 2'd1;
      end
      // Honour error only on a third-or-later, non-end beat
      if (link.tx_nullify_packet && !link.tx_packet_start
          && !link.tx_packet_end && s_nxt.beats == NULL_BEAT)
        s_nxt.null_seen = 1'b1;
      beat_state = link.tx_packet_end
        ? (s_nxt.null_seen ? TSF_GAP : TSF_IDLE) : TSF_IN_PKT;
    end
    if (f_valid && f_ready) begin
      s_nxt.o_valid = 1'b1;
      s_nxt.o_start = f_start;
      s_nxt.o_end   = f_end;
      s_nxt.o_data  = f_data;
      s_nxt.o_null  = f_null;
      s_nxt.o_pf    = f_pf;
      s_nxt.o_vfa   = f_vfa;
      s_nxt.o_vf    = f_vf;
    end else if (core_ready) begin
      s_nxt.o_valid = 1'b0;
    end
    // A nullified end owes the link one quiet cycle in the gap state
    case (s_r.state)
      TSF_IDLE: begin
        if (beat)
          s_nxt.state = beat_state;
      end
      TSF_IN_PKT: begin
        if (beat)
          s_nxt.state = beat_state;
      end
      TSF_GAP: begin
        s_nxt.state = beat ? beat_state : TSF_IDLE;
      end
      default: begin
        s_nxt.state = TSF_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Identity carry and elastic store
  // ----------------------------------------
  // Identity comes from the start-beat capture on every beat
  always_comb begin
    f_in = {clean, link.tx_packet_start, link.tx_packet_end,
            s_nxt.null_seen, s_nxt.pf, s_nxt.vfa, s_nxt.vf};
  end
  assign {f_data, f_start, f_end, f_null, f_pf, f_vfa, f_vf} = f_out;
  assign f_ready = !s_r.o_valid || core_ready;

  // Small elastic store so the core can stall without losing beats
  // Ready is the store's own: when full it backs the sender up, never drops
  tsf_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (link.tx_beat_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_out)
  );

  // ----------------------------------------
  // State register and outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) s_r <= '0;
    else s_r <= s_nxt;
  end

  assign link.tx_beat_ready  = f_in_ready;
  assign core_valid          = s_r.o_valid;
  assign core_start          = s_r.o_start;
  assign core_end            = s_r.o_end;
  assign core_data           = s_r.o_data;
  assign core_nullified      = s_r.o_null;
  assign core_pf             = s_r.o_pf;
  assign core_vf_active      = s_r.o_vfa;
  assign core_vf             = s_r.o_vf;
  assign core_parity_error   = s_r.o_perr;
  assign core_protocol_error = s_r.o_proto;
endmodule : tsf_bridge

// ==== tsf_params.svh ====
`ifndef TSF_PARAMS_SVH
`define TSF_PARAMS_SVH
`define TSF_DATA_W      256
`define TSF_QWORD_W     64
`define TSF_BYTES       32
`define TSF_EMPTY_W     2
`define TSF_PF_W        2
`define TSF_VF_W        11
`define TSF_VF_MAX      2048
`define TSF_FIFO_DEPTH  4
`define TSF_NULL_MIN_BEATS 3
`endif

// ==== tsf_pkg.sv ====
`include "tsf_params.svh"
package tsf_pkg;
  typedef logic [`TSF_DATA_W-1:0]  tsf_data_type;
  typedef logic [`TSF_BYTES-1:0]   tsf_par_type;
  typedef logic [`TSF_EMPTY_W-1:0] tsf_empty_type;
  typedef logic [`TSF_PF_W-1:0]    tsf_pf_type;
  typedef logic [`TSF_VF_W-1:0]    tsf_vf_type;
  typedef enum logic [1:0] {TSF_IDLE, TSF_IN_PKT, TSF_GAP} tsf_state_type;
endpackage : tsf_pkg

// ==== tsf_link_if.sv ====
`timescale 1ns/100ps
interface tsf_link_if;
  import tsf_pkg::*;
  logic          tx_beat_valid;
  logic          tx_beat_ready;
  logic          tx_packet_start;
  logic          tx_packet_end;
  tsf_data_type  tx_payload_bus;
  tsf_empty_type tx_last_beat_empty_qwords;
  logic          tx_nullify_packet;
  tsf_par_type   tx_byte_odd_parity;
  tsf_pf_type    tx_phys_func_number;
  logic          tx_virt_func_active;
  tsf_vf_type    tx_virt_func_offset;
  modport bridge (input tx_beat_valid, tx_packet_start, tx_packet_end,
    tx_payload_bus, tx_last_beat_empty_qwords, tx_nullify_packet,
    tx_byte_odd_parity, tx_phys_func_number, tx_virt_func_active,
    tx_virt_func_offset, output tx_beat_ready);
  modport sender (output tx_beat_valid, tx_packet_start, tx_packet_end,
    tx_payload_bus, tx_last_beat_empty_qwords, tx_nullify_packet,
    tx_byte_odd_parity, tx_phys_func_number, tx_virt_func_active,
    tx_virt_func_offset, input tx_beat_ready);
endinterface : tsf_link_if

// ==== tsf_fifo.sv ====
`timescale 1ns/100ps
module tsf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } tsf_fifo_st_type;
  tsf_fifo_st_type s_r, s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             wr, rd;

  assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = mem[s_r.rp];
  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (wr) s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
    if (rd) s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
    if (wr && !rd) s_nxt.cnt = s_r.cnt + 1'b1;
    else if (rd && !wr) s_nxt.cnt = s_r.cnt - 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) s_r <= '0;
    else s_r <= s_nxt;
    if (wr) mem[s_r.wp] <= in_data;
  end
endmodule : tsf_fifo

// ==== tsf_sender.sv ====
`timescale 1ns/100ps
`include "tsf_params.svh"
// Sender end: user side hands whole TLP beats; this end fills in the
// qualifiers and keeps the nullification and function-id obligations.
module tsf_sender import tsf_pkg::*; (
  input  wire logic          clk_sys,
  input  wire logic          reset,
  tsf_link_if.sender         link,
  input  wire logic          user_valid,
  output logic               user_ready,
  input  wire logic          user_start,
  input  wire logic          user_end,
  input  wire tsf_data_type  user_data,
  input  wire tsf_empty_type user_empty,
  input  wire logic          user_nullify,
  input  wire logic          user_parity_en,
  input  wire tsf_pf_type    user_pf,
  input  wire logic          user_vf_active,
  input  wire tsf_vf_type    user_vf
);
  typedef struct packed {
    logic          valid;
    logic          start;
    logic          fin;
    tsf_data_type  data;
    tsf_empty_type empty;
    logic          err;
    tsf_par_type   par;
    tsf_pf_type    pf;
    logic          vfa;
    tsf_vf_type    vf;
    logic [1:0]    beats;
    logic          null_done;
  } tsf_snd_st_type;
  localparam logic [1:0] NULL_BEAT = 2'(`TSF_NULL_MIN_BEATS);
  tsf_snd_st_type s_r, s_nxt;
  tsf_par_type    par_c;
  tsf_data_type   masked;
  logic           take;

  // ----------------------------------------
  // Parity and data packing
  // ----------------------------------------
  always_comb begin
    masked = user_data;
    for (int q = 0; q < 4; q++) begin
      if (user_end && (q >= 4 - int'(user_empty)))
        masked[q*`TSF_QWORD_W +: `TSF_QWORD_W] = '0;
    end
  end

  genvar b;
  generate
    for (b = 0; b < `TSF_BYTES; b++) begin : g_par
      assign par_c[b] = ~^masked[b*8 +: 8];
    end
  endgenerate

  // Hold a start back while a nullified end still sits in the beat
  // register, so the link shows one cycle with no start after that end
  assign take = (!s_r.valid || link.tx_beat_ready)
    && !(s_r.valid && s_r.fin && s_r.null_done && user_start);
  assign user_ready = take;

  // ----------------------------------------
  // Beat register
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (link.tx_beat_ready && s_r.valid) s_nxt.valid = 1'b0;
    if (take && user_valid) begin
      s_nxt.valid = 1'b1;
      s_nxt.start = user_start;
      s_nxt.fin   = user_end;
      s_nxt.data  = masked;
      s_nxt.empty = user_end ? user_empty : '0;
      s_nxt.par   = user_parity_en ? par_c : '0;
      s_nxt.pf    = user_pf;
      s_nxt.vfa   = user_vf_active;
      s_nxt.vf    = user_vf_active ? user_vf : '0;
      if (user_start) begin
        s_nxt.beats = 2'd1;
        s_nxt.null_done = 1'b0;
      end else if (s_r.beats != NULL_BEAT) s_nxt.beats = s_r.beats + 2'd1;
      // One pulse, mid packet, third beat or later, on a valid beat
      s_nxt.err = user_nullify && !user_start && !user_end
        && !s_nxt.null_done && s_nxt.beats == NULL_BEAT;
      if (s_nxt.err) s_nxt.null_done = 1'b1;
    end else if (link.tx_beat_ready) begin
      s_nxt.err = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) s_r <= '0;
    else s_r <= s_nxt;
  end

  assign link.tx_beat_valid             = s_r.valid;
  assign link.tx_packet_start           = s_r.start;
  assign link.tx_packet_end             = s_r.fin;
  assign link.tx_payload_bus            = s_r.data;
  assign link.tx_last_beat_empty_qwords = s_r.empty;
  assign link.tx_nullify_packet         = s_r.err && s_r.valid;
  assign link.tx_byte_odd_parity        = s_r.par;
  assign link.tx_phys_func_number       = s_r.pf;
  assign link.tx_virt_func_active       = s_r.vfa;
  assign link.tx_virt_func_offset       = s_r.vf;
endmodule : tsf_sender

// ==== tsf_link_monitor.sv ====
`timescale 1ns/100ps
module tsf_link_monitor import tsf_pkg::*; (
  input wire logic          clk_sys,
  input wire logic          reset,
  input wire logic          tx_beat_valid,
  input wire logic          tx_beat_ready,
  input wire logic          tx_packet_start,
  input wire logic          tx_packet_end,
  input wire tsf_data_type  tx_payload_bus,
  input wire tsf_empty_type tx_last_beat_empty_qwords,
  input wire logic          tx_nullify_packet,
  input wire tsf_par_type   tx_byte_odd_parity
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic         take;
  logic         par_ok;
  logic         nul_r;
  logic [1:0]   beat_r;
  tsf_data_type hi;
  assign take = tx_beat_valid && tx_beat_ready;
  // Shift of 256 leaves nothing, so empty 0 checks no bits
  assign hi = tx_payload_bus >> (10'h100 - 10'h40 * tx_last_beat_empty_qwords);
  always_comb begin
    par_ok = 1'b1;
    for (int i = 0; i < 32; i++) begin
      if (^{tx_payload_bus[8*i+:8], tx_byte_odd_parity[i]} != 1'b1)
        par_ok = 1'b0;
    end
  end
  // Beat index saturates at 3: only "third or later" matters
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nul_r  <= 1'b0;
      beat_r <= 2'h0;
    end else if (take) begin
      nul_r  <= !tx_packet_end && (nul_r || tx_nullify_packet);
      beat_r <= tx_packet_end ? 2'h0 : (beat_r == 2'h3 ? 2'h3 : beat_r + 2'h1);
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence s_null_end;
    take && tx_packet_end && nul_r;
  endsequence
  sequence s_null_take;
    take && tx_nullify_packet;
  endsequence
  a_gap_after_null: assert property (
    s_null_end |=> !(tx_beat_valid && tx_packet_start))
    else $error("start right after nullified end");
  a_null_with_valid: assert property (
    tx_nullify_packet |-> tx_beat_valid) else $error("nullify without valid");
  a_null_mid_packet: assert property (
    tx_nullify_packet |-> !tx_packet_start && !tx_packet_end)
    else $error("nullify on start or end beat");
  a_null_one_cycle: assert property (
    s_null_take |=> !tx_nullify_packet) else $error("nullify longer than one");
  a_null_third_beat: assert property (
    s_null_take |-> beat_r >= 2'h2 && !nul_r) else $error("nullify too early");
  a_stall_holds_beat: assert property (
    tx_beat_valid && !tx_beat_ready |=> tx_beat_valid &&
    $stable(tx_payload_bus) && $stable(tx_packet_start) &&
    $stable(tx_packet_end)) else $error("beat changed under stall");
  a_parity_odd: assert property (
    tx_beat_valid && tx_byte_odd_parity != 32'h0 |-> par_ok)
    else $error("byte parity not odd");
  a_empty_upper_zero: assert property (
    take && tx_packet_end |-> hi == 256'h0) else $error("empty qwords not zero");
endmodule : tsf_link_monitor

// ==== tb.sv ====
`timescale 1ns/100ps
module tb import tsf_pkg::*;;
  typedef struct packed {
    logic         s;
    logic         e;
    logic         n;
    tsf_pf_type   pf;
    logic         va;
    tsf_vf_type   vf;
    tsf_data_type d;
  } tsf_beat_type;
  logic clk_sys = 0, reset = 1, user_valid = 0, user_start = 0, user_end = 0;
  logic user_nullify = 0, user_parity_en = 1, user_vf_active = 0;
  logic parity_check_en = 0, core_ready = 1, user_ready, core_valid;
  logic core_start, core_end, core_nullified, core_vf_active;
  logic core_parity_error, core_protocol_error;
  tsf_data_type  user_data = 256'h0, core_data;
  tsf_empty_type user_empty = 2'h0;
  tsf_pf_type    user_pf = 2'h0, core_pf;
  tsf_vf_type    user_vf = 11'h0, core_vf;
  tsf_beat_type  got_q[$];
  int error_cnt = 0, n_compared = 0, perr_cnt = 0, proto_cnt = 0;
  tsf_link_if tsf_link_if_i ();
  tsf_sender tsf_sender_i (.clk_sys, .reset, .link(tsf_link_if_i.sender),
    .user_valid, .user_ready, .user_start, .user_end, .user_data, .user_empty,
    .user_nullify, .user_parity_en, .user_pf, .user_vf_active, .user_vf);
  tsf_bridge tsf_bridge_i (.clk_sys, .reset, .link(tsf_link_if_i.bridge),
    .parity_check_en, .core_ready, .core_valid, .core_start, .core_end,
    .core_data, .core_nullified, .core_pf, .core_vf_active, .core_vf,
    .core_parity_error, .core_protocol_error);
  tsf_link_monitor tsf_link_monitor_i (.clk_sys, .reset,
    .tx_beat_valid(tsf_link_if_i.tx_beat_valid),
    .tx_beat_ready(tsf_link_if_i.tx_beat_ready),
    .tx_packet_start(tsf_link_if_i.tx_packet_start),
    .tx_packet_end(tsf_link_if_i.tx_packet_end),
    .tx_payload_bus(tsf_link_if_i.tx_payload_bus),
    .tx_last_beat_empty_qwords(tsf_link_if_i.tx_last_beat_empty_qwords),
    .tx_nullify_packet(tsf_link_if_i.tx_nullify_packet),
    .tx_byte_odd_parity(tsf_link_if_i.tx_byte_odd_parity));
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (!reset && core_valid && core_ready)
      got_q.push_back({core_start, core_end, core_nullified, core_pf,
                       core_vf_active, core_vf, core_data});
    if (!reset && core_parity_error)
      perr_cnt++;
    if (!reset && core_protocol_error)
      proto_cnt++;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [255:0] exp, logic [255:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Id inputs are inverted on later beats: the bridge must keep the first
  task automatic pkt(int n, tsf_pf_type pf, logic va, tsf_vf_type vf,
                     tsf_empty_type em, int nb);
    tsf_data_type d;
    tsf_beat_type g;
    int k;
    got_q.delete();
    for (int b = 0; b < n; b++) begin
      @(negedge clk_sys);
      user_valid = 1'b1;
      user_start = (b == 0);
      user_end = (b == n - 1);
      user_nullify = (b == nb);
      user_data = {32{8'(b + 3)}};
      user_empty = em;
      user_pf = b == 0 ? pf : ~pf;
      user_vf_active = b == 0 ? va : ~va;
      user_vf = b == 0 ? vf : ~vf;
      #1;
      while (!user_ready)
        @(negedge clk_sys);
    end
    @(negedge clk_sys);
    user_valid = 1'b0;
    user_nullify = 1'b0;
    k = 0;
    while (got_q.size() < n && k < 300) begin
      @(negedge clk_sys);
      k++;
    end
    chk("beats", 256'(n), 256'(got_q.size()));
    for (int b = 0; b < n; b++) begin
      g = got_q[b];
      d = {32{8'(b + 3)}};
      if (b == n - 1)
        d = d & (~256'h0 >> (64 * em));
      chk("start", 256'(b == 0), 256'(g.s));
      chk("end", 256'(b == n - 1), 256'(g.e));
      chk("data", d, g.d);
      chk("null", 256'(n > 2 && nb >= 2 && nb < n - 1 && b >= nb), 256'(g.n));
      chk("pf", 256'(pf), 256'(g.pf));
      chk("vfa", 256'(va), 256'(g.va));
      chk("vf", 256'(va ? vf : 11'h0), 256'(g.vf));
    end
  endtask : pkt
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_empty;
    for (int e = 0; e < 4; e++)
      pkt(3, 2'(e), 1'b0, 11'h5, 2'(e), -1);
    pkt(4, 2'h1, 1'b1, 11'h7ff, 2'h1, -1);
    $display("empty and id test done");
  endtask : t_empty
  task automatic t_null;
    pkt(5, 2'h2, 1'b1, 11'h3, 2'h0, 2);
    pkt(3, 2'h3, 1'b0, 11'h0, 2'h2, -1);
    pkt(4, 2'h0, 1'b1, 11'h1, 2'h3, 1);
    pkt(2, 2'h1, 1'b0, 11'h0, 2'h0, 1);
    $display("nullify test done");
  endtask : t_null
  // Nullified packet straight into a one-beat packet: the start must wait
  task automatic t_gap;
    int k;
    got_q.delete();
    for (int b = 0; b < 5; b++) begin
      @(negedge clk_sys);
      user_valid = 1'b1;
      user_start = (b == 0 || b == 4);
      user_end = (b >= 3);
      user_nullify = (b == 2);
      user_data = {32{8'(b + 3)}};
      user_empty = 2'h0;
      #1;
      if (b == 4)
        chk("gap ready", 256'h0, 256'(user_ready));
      while (!user_ready)
        @(negedge clk_sys);
    end
    @(negedge clk_sys);
    user_valid = 1'b0;
    k = 0;
    while (got_q.size() < 5 && k < 300) begin
      @(negedge clk_sys);
      k++;
    end
    chk("gap beats", 256'h5, 256'(got_q.size()));
    chk("gap null", 256'h1, 256'(got_q[3].n));
    chk("gap next", 256'h0, 256'(got_q[4].n));
    chk("proto", 256'h0, 256'(proto_cnt));
    $display("gap test done");
  endtask : t_gap
  task automatic t_stall;
    core_ready = 1'b0;
    fork
      pkt(7, 2'h2, 1'b1, 11'h40, 2'h2, 3);
      begin
        repeat (30) @(negedge clk_sys);
        chk("link ready", 256'h0, 256'(tsf_link_if_i.tx_beat_ready));
        core_ready = 1'b1;
      end
    join
    $display("stall test done");
  endtask : t_stall
  task automatic t_parity;
    parity_check_en = 1'b1;
    perr_cnt = 0;
    pkt(1, 2'h0, 1'b0, 11'h0, 2'h3, -1);
    chk("parity ok", 256'h0, 256'(perr_cnt));
    user_parity_en = 1'b0;
    pkt(1, 2'h0, 1'b0, 11'h0, 2'h0, -1);
    chk("parity bad", 256'h1, 256'(perr_cnt));
    parity_check_en = 1'b0;
    user_parity_en = 1'b1;
    $display("parity test done");
  endtask : t_parity
  initial begin
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    t_empty();
    t_null();
    t_gap();
    t_stall();
    t_parity();
    tally_and_finish();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #1000000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb
